/* rtl/ifw_defs.vh */
// Overview of operation
// - desaturation_detect flag bit 7; bits 6-5 read zero
// - overtemperature event sets flag bit 4
// - rise select sets vout flag on entry
// - fall select sets vout flag on exit
// - gate drive undervoltage sets flag bit 2
// - vin overvoltage flag bit 1, edge selected
// - vin undervoltage flag bit 0, edge selected
// - interrupt pushes only return pc
// - only sleep instruction enters power-down
// - sleep entry clears watchdog, keeps it running
// - sleep entry clears powerdown status bit
// - sleep entry sets timeout status bit
// - core clock gated off while asleep
// - io pins hold drive state asleep
// - non-watchdog resets stay effective asleep
// - power-on reset wakes from sleep
// - sleep leaves analog enables unchanged
// - pin/por wake resets; others continue
// - of the interrupts, only pin-change and int pin wake
// - sleep prefetches next program address
// - wake needs enable, ignores global enable
// - after wake, next instruction then vector
// - interrupt or watchdog wake clears the watchdog
// - flags set regardless of enables
// - pending enabled interrupt makes sleep nop
`ifndef IFW_DEFS_VH
`define IFW_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define IFW_OFS_FLAGS 8'h00
`define IFW_OFS_FEN 8'h04
`define IFW_OFS_GCTL 8'h08
`define IFW_OFS_PFLG 8'h0c
`define IFW_OFS_PEN 8'h10
`define IFW_OFS_OPT 8'h14
`define IFW_OFS_ESEL 8'h18
`define IFW_OFS_STAT 8'h1c
`define IFW_OFS_ANA 8'h20

// ----------------------------------------
// field positions
// ----------------------------------------
`define IFW_FB_DESATURATION_DETECT 7
`define IFW_FB_OTEMP 4
`define IFW_FB_VOUTOV 3
`define IFW_FB_GATEUV 2
`define IFW_FB_VINOV 1
`define IFW_FB_VINUV 0
`define IFW_GB_GIE 7
`define IFW_GB_PERIPH_IRQ_ENABLE 6
`define IFW_GB_T0IE 5
`define IFW_GB_INTE 4
`define IFW_GB_IOCE 3
`define IFW_GB_T0IF 2
`define IFW_GB_INTF 1
`define IFW_GB_IOCF 0
`define IFW_OB_INTEDG 6
`define IFW_SB_PDN 0
`define IFW_SB_TON 1
`define IFW_SB_ASLEEP 2

// ----------------------------------------
// masks and reset values
// ----------------------------------------
`define IFW_FLAGS_MASK 8'h9f
`define IFW_PFLG_MASK 8'h7f
`define IFW_RST_FLAGS 8'h00
`define IFW_RST_GCTL 8'h00
`define IFW_RST_OPT 8'hff
`define IFW_RST_ESEL 8'h15
`define IFW_RST_ANA 8'h00

// ----------------------------------------
// bus responses
// ----------------------------------------
`define IFW_RESP_OKAY 2'b00
`define IFW_RESP_SLVERR 2'b10

`endif

/* rtl/ifw_sync2.v */
`timescale 1ns/100ps
module ifw_sync2 #(
    parameter W = 1
) (
    // clock and control
    input wire clk_sys,
    input wire rst,
    input wire clkEn,
    // async levels in, synced out
    input wire [W-1:0] asyncIn,
    output wire [W-1:0] syncOut
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    always @(posedge clk_sys) begin
        if (rst) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else if (clkEn) begin
            meta_r <= asyncIn;
            sync_r <= meta_r;
        end
    end

    assign syncOut = sync_r;
endmodule // ifw_sync2

/* rtl/ifw_edge_det.v */
`timescale 1ns/100ps
module ifw_edge_det #(
    parameter W = 1
) (
    // clock and control
    input wire clk_sys,
    input wire rst,
    input wire clkEn,
    // synced levels and edge selects
    input wire [W-1:0] level,
    input wire [W-1:0] riseSel,
    input wire [W-1:0] fallSel,
    // one-cycle events
    output wire [W-1:0] edgeOut
);
    reg [W-1:0] prev_r;

    always @(posedge clk_sys) begin
        if (rst) begin
            prev_r <= {W{1'b0}};
        end else if (clkEn) begin
            prev_r <= level;
        end
    end

    // compare against previous sample
    assign edgeOut = (riseSel & level & ~prev_r) |
                   (fallSel & ~level & prev_r);
endmodule // ifw_edge_det

/* rtl/ifw_irq_sleep.v */
`timescale 1ns/100ps
`include "ifw_defs.vh"
module ifw_irq_sleep #(
    parameter NIOC = 8,
    parameter PCW = 13
) (
    // clock, reset, enable
    input wire clk_sys,
    input wire rst,
    input wire clkEn,
    // axi4-lite write
    input wire [7:0] s_axil_awaddr,
    input wire s_axil_awvalid,
    output wire s_axil_awready,
    input wire [31:0] s_axil_wdata,
    input wire [3:0] s_axil_wstrb,
    input wire s_axil_wvalid,
    output wire s_axil_wready,
    output wire [1:0] s_axil_bresp,
    output wire s_axil_bvalid,
    input wire s_axil_bready,
    // axi4-lite read
    input wire [7:0] s_axil_araddr,
    input wire s_axil_arvalid,
    output wire s_axil_arready,
    output wire [31:0] s_axil_rdata,
    output wire [1:0] s_axil_rresp,
    output wire s_axil_rvalid,
    input wire s_axil_rready,
    // pins and fault comparators
    input wire extResetPin,
    input wire porPin,
    input wire intPin,
    input wire [NIOC-1:0] iocPin,
    input wire desatDetect,
    input wire overtempDetect,
    input wire voutOvDetect,
    input wire gateUvDetect,
    input wire vinOvDetect,
    input wire vinUvDetect,
    // core side
    input wire sleepExec,
    input wire [PCW-1:0] corePc,
    input wire instrRetire,
    input wire timer0Ovf,
    input wire [6:0] periphEvt,
    input wire wdtTimeout,
    input wire wdtEnable,
    // sleep and vector control
    output wire coreClkEn,
    output wire ioHold,
    output wire resetReq,
    output wire wakeContinue,
    output wire sleepNop,
    output wire prefetchReq,
    output wire [PCW-1:0] prefetchAddr,
    output wire irqVector,
    output wire stackPush,
    output wire [PCW-1:0] stackPushPc,
    // watchdog and analog
    output wire wdtClear,
    output wire wdtRunning,
    output wire [7:0] analogEnable,
    output wire analogSupplyOn
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam ST_RUN = 3'b001;
    localparam ST_SLEEP = 3'b010;
    localparam ST_POST = 3'b100;
    localparam NS = 9 + NIOC;
    localparam NE = 7 + NIOC;

    // ----------------------------------------
    // functions
    // ----------------------------------------
    function pend8;
        input [7:0] flg;
        input [7:0] en;
        begin
            pend8 = |(flg & en);
        end
    endfunction

    function mapped;
        input [7:0] a;
        begin
            case (a)
                `IFW_OFS_FLAGS, `IFW_OFS_FEN, `IFW_OFS_GCTL,
                `IFW_OFS_PFLG, `IFW_OFS_PEN, `IFW_OFS_OPT,
                `IFW_OFS_ESEL, `IFW_OFS_STAT, `IFW_OFS_ANA:
                    mapped = 1'b1;
                default:
                    mapped = 1'b0;
            endcase
        end
    endfunction

    function [PCW-1:0] pcNext;
        input [PCW-1:0] pc;
        begin
            pcNext = pc + {{(PCW-1){1'b0}}, 1'b1};
        end
    endfunction

    // ----------------------------------------
    // synchronisers and edges
    // ----------------------------------------
    wire [NS-1:0] syn;
    wire extSync = syn[NS-1];
    wire porSync = syn[NS-2];
    wire rstAll = rst | porSync;
    wire rstCtl = rstAll | extSync;
    wire [NE-1:0] edgeEvt;
    wire [NE-1:0] riseSel;
    wire [NE-1:0] fallSel;
    reg [7:0] esel_r;
    reg [7:0] opt_r;

    ifw_sync2 #(.W(NS)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .clkEn(clkEn),
        .asyncIn({extResetPin, porPin, intPin, desatDetect,
            overtempDetect, voutOvDetect, gateUvDetect,
            vinOvDetect, vinUvDetect, iocPin}),
        .syncOut(syn)
    );

    // order: int, desaturation_detect, otemp, vout, gate, vinov, vinuv, ioc
    assign riseSel = {opt_r[`IFW_OB_INTEDG], 1'b1, 1'b1,
        esel_r[0], 1'b1, esel_r[2], esel_r[4], {NIOC{1'b1}}};
    assign fallSel = {~opt_r[`IFW_OB_INTEDG], 1'b0, 1'b0,
        esel_r[1], 1'b0, esel_r[3], esel_r[5], {NIOC{1'b1}}};

    ifw_edge_det #(.W(NE)) u_edge (
        .clk_sys(clk_sys),
        .rst(rstCtl),
        .clkEn(clkEn),
        .level(syn[NE-1:0]),
        .riseSel(riseSel),
        .fallSel(fallSel),
        .edgeOut(edgeEvt)
    );

    wire intSet = edgeEvt[NE-1];
    wire iocSet = |edgeEvt[NIOC-1:0];
    wire [7:0] faultSet;
    assign faultSet[`IFW_FB_DESATURATION_DETECT] = edgeEvt[NE-2];
    assign faultSet[6:5] = 2'b00;
    assign faultSet[`IFW_FB_OTEMP] = edgeEvt[NE-3];
    assign faultSet[`IFW_FB_VOUTOV] = edgeEvt[NE-4];
    assign faultSet[`IFW_FB_GATEUV] = edgeEvt[NE-5];
    assign faultSet[`IFW_FB_VINOV] = edgeEvt[NE-6];
    assign faultSet[`IFW_FB_VINUV] = edgeEvt[NE-7];

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    reg awHeld_r;
    reg [7:0] awAddr_r;
    reg wHeld_r;
    reg [31:0] wData_r;
    reg [3:0] wStrb_r;
    reg bvalid_r;
    reg [1:0] bresp_r;
    reg rvalid_r;
    reg [31:0] rdata_r;
    reg [1:0] rresp_r;

    wire doWrite = awHeld_r & wHeld_r & ~bvalid_r;
    wire wrEn = doWrite & wStrb_r[0];
    wire [7:0] wByte = wData_r[7:0];
    assign s_axil_awready = clkEn & ~awHeld_r & ~bvalid_r;
    assign s_axil_wready = clkEn & ~wHeld_r & ~bvalid_r;
    assign s_axil_arready = clkEn & ~rvalid_r;
    assign s_axil_bvalid = bvalid_r;
    assign s_axil_bresp = bresp_r;
    assign s_axil_rvalid = rvalid_r;
    assign s_axil_rdata = rdata_r;
    assign s_axil_rresp = rresp_r;

    always @(posedge clk_sys) begin
        if (rst) begin
            awHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
            wHeld_r <= 1'b0;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= `IFW_RESP_OKAY;
        end else if (clkEn) begin
            if (s_axil_awvalid && s_axil_awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axil_awaddr;
            end
            if (s_axil_wvalid && s_axil_wready) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axil_wdata;
                wStrb_r <= s_axil_wstrb;
            end
            if (doWrite) begin
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= mapped(awAddr_r) ? `IFW_RESP_OKAY : `IFW_RESP_SLVERR;
            end else if (bvalid_r && s_axil_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [7:0] fflg_r;
    reg [7:0] fen_r;
    reg [7:0] gctl_r;
    reg [7:0] pflg_r;
    reg [7:0] pen_r;
    reg [7:0] ana_r;
    reg pdN_r;
    reg toN_r;
    reg [2:0] state_r;
    reg [2:0] state_nxt;

    wire wrFlags = wrEn && (awAddr_r == `IFW_OFS_FLAGS);
    wire wrGctl = wrEn && (awAddr_r == `IFW_OFS_GCTL);
    wire wrPflg = wrEn && (awAddr_r == `IFW_OFS_PFLG);
    wire periph_irq_enable = gctl_r[`IFW_GB_PERIPH_IRQ_ENABLE];
    wire pendAny = (periph_irq_enable & (pend8(fflg_r, fen_r) | pend8(pflg_r, pen_r))) |
        pend8({5'h00, gctl_r[2:0]}, {5'h00, gctl_r[5:3]});
    // of the interrupts, only int pin and pin change may wake
    wire wakeIrq = pend8({6'h00, gctl_r[`IFW_GB_INTF], gctl_r[`IFW_GB_IOCF]},
        {6'h00, gctl_r[`IFW_GB_INTE], gctl_r[`IFW_GB_IOCE]});
    wire inRun = state_r[0];
    wire takeVec = inRun & gctl_r[`IFW_GB_GIE] & pendAny;

    reg [7:0] fflg_nxt;
    reg [7:0] gctl_nxt;
    reg [7:0] pflg_nxt;

    always @* begin
        // set wins over a software clear
        fflg_nxt = (wrFlags ? wByte : fflg_r) | faultSet;
        fflg_nxt = fflg_nxt & `IFW_FLAGS_MASK;
        pflg_nxt = ((wrPflg ? wByte : pflg_r) | {1'b0, periphEvt}) & `IFW_PFLG_MASK;
        gctl_nxt = wrGctl ? wByte : gctl_r;
        if (takeVec) begin
            gctl_nxt[`IFW_GB_GIE] = 1'b0;
        end
        gctl_nxt[2:0] = gctl_nxt[2:0] | {timer0Ovf, intSet, iocSet};
    end

    always @(posedge clk_sys) begin
        if (rstCtl) begin
            fflg_r <= `IFW_RST_FLAGS;
            fen_r <= 8'h00;
            gctl_r <= `IFW_RST_GCTL;
            pflg_r <= 8'h00;
            pen_r <= 8'h00;
            opt_r <= `IFW_RST_OPT;
            esel_r <= `IFW_RST_ESEL;
            ana_r <= `IFW_RST_ANA;
        end else if (clkEn) begin
            fflg_r <= fflg_nxt;
            gctl_r <= gctl_nxt;
            pflg_r <= pflg_nxt;
            if (wrEn && awAddr_r == `IFW_OFS_FEN) begin
                fen_r <= wByte & `IFW_FLAGS_MASK;
            end
            if (wrEn && awAddr_r == `IFW_OFS_PEN) begin
                pen_r <= wByte & `IFW_PFLG_MASK;
            end
            if (wrEn && awAddr_r == `IFW_OFS_OPT) begin
                opt_r <= wByte;
            end
            if (wrEn && awAddr_r == `IFW_OFS_ESEL) begin
                esel_r <= wByte & 8'h3f;
            end
            // sleep never touches this register
            if (wrEn && awAddr_r == `IFW_OFS_ANA) begin
                ana_r <= wByte;
            end
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    reg [7:0] rdByte;

    always @* begin
        case (s_axil_araddr)
            `IFW_OFS_FLAGS: rdByte = fflg_r;
            `IFW_OFS_FEN: rdByte = fen_r;
            `IFW_OFS_GCTL: rdByte = gctl_r;
            `IFW_OFS_PFLG: rdByte = pflg_r;
            `IFW_OFS_PEN: rdByte = pen_r;
            `IFW_OFS_OPT: rdByte = opt_r;
            `IFW_OFS_ESEL: rdByte = esel_r;
            `IFW_OFS_STAT: rdByte = {5'h00, state_r[1], toN_r, pdN_r};
            `IFW_OFS_ANA: rdByte = ana_r;
            default: rdByte = 8'h00;
        endcase
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `IFW_RESP_OKAY;
        end else if (clkEn) begin
            if (s_axil_arvalid && !rvalid_r) begin
                rvalid_r <= 1'b1;
                rdata_r <= {24'h000000, rdByte};
                rresp_r <= mapped(s_axil_araddr) ? `IFW_RESP_OKAY : `IFW_RESP_SLVERR;
            end else if (rvalid_r && s_axil_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // power-down sequencer
    // ----------------------------------------
    reg wdtClear_r;
    reg wake_r;
    reg nop_r;
    reg pref_r;
    reg [PCW-1:0] prefAddr_r;
    reg vec_r;
    reg [PCW-1:0] pushPc_r;
    reg resetReq_r;

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (sleepExec && !pendAny) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wakeIrq || wdtTimeout) begin
                    state_nxt = ST_POST;
                end
            end
            ST_POST: begin
                if (instrRetire) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    wire enterSleep = inRun & sleepExec & ~pendAny;
    wire leaveSleep = state_r[1] & ~state_nxt[1];

    always @(posedge clk_sys) begin
        // por or pin reset wakes by resetting
        if (rstCtl) begin
            state_r <= ST_RUN;
            wdtClear_r <= 1'b0;
            wake_r <= 1'b0;
            nop_r <= 1'b0;
            pref_r <= 1'b0;
            prefAddr_r <= {PCW{1'b0}};
            vec_r <= 1'b0;
            pushPc_r <= {PCW{1'b0}};
        end else if (clkEn) begin
            state_r <= state_nxt;
            wdtClear_r <= enterSleep | leaveSleep;
            wake_r <= leaveSleep;
            nop_r <= inRun & sleepExec & pendAny;
            pref_r <= inRun & sleepExec;
            if (inRun && sleepExec) begin
                prefAddr_r <= pcNext(corePc);
            end
            vec_r <= takeVec;
            if (takeVec) begin
                pushPc_r <= pcNext(corePc);
            end
        end
    end

    // status bits survive a pin reset
    always @(posedge clk_sys) begin
        if (rstAll) begin
            pdN_r <= 1'b1;
            toN_r <= 1'b1;
        end else if (clkEn) begin
            if (enterSleep) begin
                pdN_r <= 1'b0;
                toN_r <= 1'b1;
            end else if (wdtTimeout && !nop_r) begin
                toN_r <= 1'b0;
            end
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            resetReq_r <= 1'b0;
        end else if (clkEn) begin
            resetReq_r <= porSync | extSync;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign coreClkEn = ~state_r[1];
    assign ioHold = state_r[1];
    assign analogSupplyOn = ~state_r[1];
    assign analogEnable = ana_r;
    assign resetReq = resetReq_r;
    assign wakeContinue = wake_r;
    assign sleepNop = nop_r;
    assign prefetchReq = pref_r;
    assign prefetchAddr = prefAddr_r;
    assign irqVector = vec_r;
    assign stackPush = vec_r;
    assign stackPushPc = pushPc_r;
    assign wdtClear = wdtClear_r;
    assign wdtRunning = wdtEnable;
endmodule // ifw_irq_sleep

/* verification/ifw_irq_sleep_checker.sv */
`timescale 1ns/100ps
module ifw_irq_sleep_checker #(
    parameter NIOC = 8,
    parameter PCW = 13
) (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // core side
    input wire sleepExec,
    input wire [PCW-1:0] corePc,
    input wire wdtEnable,
    // sleep and vector control
    input wire coreClkEn,
    input wire ioHold,
    input wire resetReq,
    input wire wakeContinue,
    input wire sleepNop,
    input wire prefetchReq,
    input wire [PCW-1:0] prefetchAddr,
    input wire irqVector,
    input wire stackPush,
    input wire wdtClear,
    input wire wdtRunning,
    input wire [7:0] analogEnable
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    sleep_prefetch_a: assert property (sleepExec && coreClkEn |=> prefetchReq)
        else $error("sleep without prefetch");
    prefetch_addr_a: assert property (prefetchReq |-> prefetchAddr == $past(corePc) + 1'h1)
        else $error("prefetch address wrong");
    sleep_cause_a: assert property ($fell(coreClkEn) |-> $past(sleepExec))
        else $error("powerdown without sleep");
    gate_hold_a: assert property (coreClkEn != ioHold)
        else $error("clock gate and pin hold disagree");
    entry_wdt_a: assert property ($fell(coreClkEn) |-> wdtClear && wdtRunning == wdtEnable)
        else $error("watchdog not cleared at entry");
    wake_clear_a: assert property (wakeContinue |-> wdtClear && coreClkEn ##1 !irqVector)
        else $error("wake without clear or early vector");
    nop_quiet_a: assert property (sleepNop |-> coreClkEn && !wdtClear && prefetchReq)
        else $error("nop sleep had side effects");
    vector_push_a: assert property (irqVector == stackPush)
        else $error("vector and push differ");
    reset_wake_a: assert property (resetReq |=> coreClkEn && !ioHold)
        else $error("reset did not wake");
    analog_keep_a: assert property (sleepExec |=> $stable(analogEnable))
        else $error("analog enables changed");

    cover property ($fell(coreClkEn));
    cover property (wakeContinue);
    cover property (sleepNop);
    cover property (irqVector);
endmodule // ifw_irq_sleep_checker

bind ifw_irq_sleep ifw_irq_sleep_checker #(.NIOC(NIOC), .PCW(PCW)) ifwChk (
    .clk_sys, .rst, .sleepExec, .corePc, .wdtEnable, .coreClkEn, .ioHold, .resetReq,
    .wakeContinue, .sleepNop, .prefetchReq, .prefetchAddr, .irqVector, .stackPush,
    .wdtClear, .wdtRunning, .analogEnable);

/* verification/ifw_core_model.sv */
`timescale 1ns/100ps
module ifw_core_model #(
    parameter PCW = 13,
    parameter RET_DLY = 3
) (
    // clock and gate
    input wire clk_sys,
    input wire coreClkEn,
    // core outputs
    output logic sleepExec = 1'h0,
    output logic [PCW-1:0] corePc = {PCW{1'h0}},
    output logic instrRetire = 1'h0
);
    int cnt = 0;
    logic enQ = 1'h1;

    // retire the instruction after sleep once the gated clock returns
    always @(posedge clk_sys) begin
        enQ <= coreClkEn;
        instrRetire <= (cnt == 1);
        if (coreClkEn && !enQ) cnt <= RET_DLY;
        else if (cnt != 0) cnt <= cnt - 1;
    end

    task automatic doSleep(input logic [PCW-1:0] pc);
        corePc <= pc;
        sleepExec <= 1'h1;
        @(posedge clk_sys);
        sleepExec <= 1'h0;
    endtask
endmodule // ifw_core_model

/* verification/irq_flags_sleep_wake_tb_top.sv */
`timescale 1ns/100ps
`include "ifw_defs.vh"
module irq_flags_sleep_wake_tb_top;
    localparam int PCW = 13;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
    logic [31:0] s_axil_wdata = 32'h0;
    logic [3:0] s_axil_wstrb = 4'hf;
    logic s_axil_awvalid = 1'h0, s_axil_wvalid = 1'h0, s_axil_bready = 1'h1;
    logic s_axil_arvalid = 1'h0, s_axil_rready = 1'h1;
    wire s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
    wire [1:0] s_axil_bresp, s_axil_rresp;
    wire [31:0] s_axil_rdata;
    logic extResetPin = 1'h0, porPin = 1'h0, intPin = 1'h0, wdtTimeout = 1'h0, clkEn = 1'h1;
    logic desatDetect = 1'h0, overtempDetect = 1'h0, gateUvDetect = 1'h0, wdtEnable = 1'h1;
    logic voutOvDetect = 1'h0, vinOvDetect = 1'h0, vinUvDetect = 1'h0;
    logic [7:0] iocPin = 8'h00;
    wire sleepExec, instrRetire, coreClkEn, ioHold, resetReq, wakeContinue, sleepNop;
    wire prefetchReq, irqVector, stackPush, wdtClear, wdtRunning, analogSupplyOn;
    wire [PCW-1:0] corePc, prefetchAddr, stackPushPc;
    wire [7:0] analogEnable;
    int fails = 0, check_count = 0, wakes = 0, vecs = 0;
    logic [PCW-1:0] pushPc;
    logic [31:0] rd;
    logic [1:0] resp;

    ifw_irq_sleep dut (
        .clk_sys, .rst, .clkEn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready,
        .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp,
        .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready,
        .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .extResetPin, .porPin,
        .intPin, .iocPin, .desatDetect, .overtempDetect, .voutOvDetect, .gateUvDetect,
        .vinOvDetect, .vinUvDetect, .sleepExec, .corePc, .instrRetire, .timer0Ovf(1'h0),
        .periphEvt(7'h00), .wdtTimeout, .wdtEnable, .coreClkEn, .ioHold, .resetReq,
        .wakeContinue, .sleepNop, .prefetchReq, .prefetchAddr, .irqVector, .stackPush,
        .stackPushPc, .wdtClear, .wdtRunning, .analogEnable, .analogSupplyOn);
    ifw_core_model #(.PCW(PCW)) core (
        .clk_sys, .coreClkEn, .sleepExec, .corePc, .instrRetire);

    initial forever #4 clk_sys = ~clk_sys;

    always @(negedge clk_sys) begin
        if (wakeContinue === 1'h1) wakes++;
        if (irqVector === 1'h1) begin
            vecs++;
            pushPc = stackPushPc;
        end
    end

    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ta, tw, tb;
        s_axil_awaddr <= a;
        s_axil_wdata <= {24'h0, d};
        s_axil_awvalid <= 1'h1;
        s_axil_wvalid <= 1'h1;
        do begin
            @(negedge clk_sys);
            ta = s_axil_awvalid && s_axil_awready;
            tw = s_axil_wvalid && s_axil_wready;
            tb = s_axil_bvalid;
            resp = s_axil_bresp;
            @(posedge clk_sys);
            if (ta) s_axil_awvalid <= 1'h0;
            if (tw) s_axil_wvalid <= 1'h0;
        end while (!tb);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input string n);
        logic ta, tr;
        s_axil_araddr <= a;
        s_axil_arvalid <= 1'h1;
        do begin
            @(negedge clk_sys);
            ta = s_axil_arvalid && s_axil_arready;
            tr = s_axil_rvalid;
            rd = s_axil_rdata;
            resp = s_axil_rresp;
            @(posedge clk_sys);
            if (ta) s_axil_arvalid <= 1'h0;
        end while (!tr);
        chk(n, rd, e);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'h0;
        @(posedge clk_sys);
        rdChk(`IFW_OFS_FLAGS, 32'h00, "flags reset");
        rdChk(8'h24, 32'h00, "unmapped data");
        chk("unmapped resp", resp, `IFW_RESP_SLVERR);
        {desatDetect, overtempDetect, gateUvDetect} <= 3'h7;
        tick(4);
        rdChk(`IFW_OFS_FLAGS, 32'h94, "fault flags");
        wr(`IFW_OFS_FLAGS, 8'hff);
        rdChk(`IFW_OFS_FLAGS, 32'h9f, "flag width");
        wr(`IFW_OFS_FLAGS, 8'h00);
        rdChk(`IFW_OFS_FLAGS, 32'h00, "flag clear");
        wr(`IFW_OFS_ESEL, 8'h2a);
        {voutOvDetect, vinOvDetect, vinUvDetect} <= 3'h7;
        tick(4);
        rdChk(`IFW_OFS_FLAGS, 32'h00, "wrong edge");
        {voutOvDetect, vinOvDetect, vinUvDetect} <= 3'h0;
        tick(4);
        rdChk(`IFW_OFS_FLAGS, 32'h0b, "fall edge");
        wr(`IFW_OFS_ESEL, 8'h15);
        wr(`IFW_OFS_FLAGS, 8'h00);
        {voutOvDetect, vinOvDetect, vinUvDetect} <= 3'h7;
        tick(4);
        rdChk(`IFW_OFS_FLAGS, 32'h0b, "rise edge");
        wr(`IFW_OFS_FLAGS, 8'h00);
        wr(`IFW_OFS_ANA, 8'h5a);
        s_axil_wstrb <= 4'h0;
        wr(`IFW_OFS_ANA, 8'h33);
        s_axil_wstrb <= 4'hf;
        wr(`IFW_OFS_GCTL, 8'h18);
        // wake by int pin, pin change, watchdog
        for (int k = 0; k < 3; k++) begin
            core.doSleep(13'h120 + k);
            tick(2);
            chk("gated", {analogSupplyOn, ioHold, coreClkEn}, 3'h2);
            rdChk(`IFW_OFS_STAT, 32'h06, "asleep status");
            chk("prefetch", prefetchAddr, 13'h121 + k);
            if (k == 0) intPin <= 1'h1;
            else if (k == 1) iocPin <= 8'h01;
            else wdtTimeout <= 1'h1;
            @(posedge clk_sys);
            wdtTimeout <= 1'h0;
            while (coreClkEn !== 1'h1) @(posedge clk_sys);
            tick(6);
            rdChk(`IFW_OFS_STAT, (k == 2) ? 32'h00 : 32'h02, "woken status");
            rdChk(`IFW_OFS_ANA, 32'h5a, "analog kept");
            wr(`IFW_OFS_GCTL, 8'h18);
        end
        chk("wakes", wakes, 3);
        chk("no vector", vecs, 0);
        core.doSleep(13'h200);
        wr(`IFW_OFS_GCTL, 8'h58);
        wr(`IFW_OFS_FEN, 8'h80);
        desatDetect <= 1'h0;
        tick(4);
        desatDetect <= 1'h1;
        tick(6);
        chk("fault no wake", coreClkEn, 1'h0);
        {clkEn, wdtTimeout} <= 2'h1;
        tick(2);
        chk("frozen", coreClkEn, 1'h0);
        clkEn <= 1'h1;
        @(posedge clk_sys);
        wdtTimeout <= 1'h0;
        while (coreClkEn !== 1'h1) @(posedge clk_sys);
        tick(6);
        core.doSleep(13'h300);
        tick(2);
        chk("nop sleep", coreClkEn, 1'h1);
        rdChk(`IFW_OFS_STAT, 32'h00, "nop status");
        wr(`IFW_OFS_GCTL, 8'hd8);
        tick(2);
        chk("vectors", vecs, 1);
        chk("pushed pc", pushPc, 13'h301);
        rdChk(`IFW_OFS_GCTL, 32'h58, "gie after vector");
        {desatDetect, overtempDetect, gateUvDetect} <= 3'h0;
        {voutOvDetect, vinOvDetect, vinUvDetect} <= 3'h0;
        tick(4);
        wr(`IFW_OFS_FLAGS, 8'h00);
        wr(`IFW_OFS_GCTL, 8'h00);
        wdtEnable <= 1'h0;
        // external reset, then power-on reset, while asleep
        for (int p = 0; p < 2; p++) begin
            core.doSleep(13'h400);
            tick(2);
            if (p == 0) extResetPin <= 1'h1;
            else porPin <= 1'h1;
            tick(6);
            chk("reset wake", {resetReq, coreClkEn}, 2'h3);
            {extResetPin, porPin} <= 2'h0;
            tick(4);
            rdChk(`IFW_OFS_STAT, p ? 32'h03 : 32'h02, "reset status");
        end
        rdChk(`IFW_OFS_FLAGS, 32'h00, "flags after por");
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        summarize();
    end
endmodule // irq_flags_sleep_wake_tb_top
